// >>> hw/dps_pkg.sv
package dps_pkg;

  // command-address phase
  localparam int CA_BYTES = 6;
  localparam int CA_BITS = CA_BYTES * 8;
  localparam int CA_CNT_W = 3;
  localparam int CA_READ_BIT = 47;
  localparam int CA_LINEAR_BIT = 45;
  localparam int CA_ROW_LSB = 16;
  localparam int CA_COL_W = 3;

  // array word addressing, 16-bit words
  localparam int WORD_ADDR_W = 25;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;

  // wrapped group of 16 bytes is 8 words; each step doubles it
  localparam int WRAP_WORDS_MIN = 8;
  localparam int BURST_CNT_W = 7;

  // latency counted in bus clocks
  localparam int LAT_W = 4;
  localparam int LAT_CNT_W = LAT_W + 1;

  // internal refresh
  localparam int REFRESH_PERIOD_DEFAULT = 2000;
  localparam int REFRESH_BUSY_CYC = 4;
  localparam int REFRESH_CNT_W = 16;

  // reset values of the pin drivers
  localparam logic [7:0] DQ_RESET = 8'h00;
  localparam logic READ_WRITE_STROBE_RESET = 1'b0;

  typedef enum logic [1:0] {
    DPS_WRAP_16B,
    DPS_WRAP_32B,
    DPS_WRAP_64B,
    DPS_WRAP_128B
  } dps_wrap_t;

  typedef enum {
    DPS_IDLE,
    DPS_CA,
    DPS_LAT,
    DPS_DATA
  } dps_state_t;

  typedef struct packed {
    logic [BYTE_W-1:0] dq;
    logic read_write_strobe;
    logic cs_n;
    logic ck;
    logic rst_n;
  } dps_pins_t;

  typedef struct packed {
    logic we;
    logic [WORD_ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
    logic [1:0] keep_n;
  } dps_mem_req_t;

endpackage

// >>> hw/dps_fifo.sv
`timescale 1ns/1ps

// shift-register buffer: the head is always slot 0, so the output is a flop
module dps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  logic [WIDTH-1:0] slot_q [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic push;
  logic pop;

  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("dps_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  assign in_ready = ~vld_q[DEPTH-1];
  assign out_valid = vld_q[0];
  assign out_data = slot_q[0];
  assign push = in_valid & in_ready;
  assign pop = vld_q[0] & out_ready;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vld_q <= '0;
    end else if (pop && !push) begin
      vld_q <= {1'b0, vld_q[DEPTH-1:1]};
    end else if (push && !pop) begin
      vld_q <= {vld_q[DEPTH-2:0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        // new word lands in the first free slot after any shift
        if (pop) begin
          if (i < DEPTH - 1 && vld_q[i+1]) begin
            slot_q[i] <= slot_q[i+1];
          end else if (push && (i == 0 || vld_q[i])) begin
            slot_q[i] <= in_data;
          end
        end else if (push && !vld_q[i] && (i == 0 || vld_q[i-1])) begin
          slot_q[i] <= in_data;
        end
      end
    end
  end

endmodule

// >>> hw/dps_bus_slave.sv
`timescale 1ns/1ps

// What this block does
// - chip select opens, six bytes, latency, data
// - two bytes per bus clock form one word
// - capture command bytes on bus clock edges
// - strobe output during command phase shows latency
// - strobe toggles with read data bytes
// - write strobe high masks byte, low writes
// - refresh runs internally, starts only while bus idle
// - dual die always uses doubled latency
// - linear burst wraps within current die
// - linear and 16 to 128 byte wraps
// - hybrid: one wrap then linear
// - strobe high in command phase doubles latency
// - wrap runs to group end, then start
// - reset pin low releases pins, back idle
module dps_bus_slave #(
  parameter bit DUAL_DIE = 1'b1,
  parameter int REFRESH_PERIOD = dps_pkg::REFRESH_PERIOD_DEFAULT,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus pins
  input wire logic bus_clock,
  input wire logic cs_n,
  input wire logic reset_pin_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic read_write_strobe_in,
  output logic read_write_strobe_out,
  output logic read_write_strobe_oe,
  // configuration
  input wire logic [dps_pkg::LAT_W-1:0] cfg_latency,
  input wire dps_pkg::dps_wrap_t cfg_wrap,
  input wire logic cfg_hybrid,
  // array request stream
  output logic mem_req_valid,
  output dps_pkg::dps_mem_req_t mem_req,
  input wire logic mem_req_ready,
  // array read answers
  input wire logic mem_rsp_valid,
  input wire logic [dps_pkg::WORD_W-1:0] mem_rsp_data,
  output logic mem_rsp_ready,
  // status
  output logic refresh_active,
  output logic lost_word
);

  if (REFRESH_PERIOD <= dps_pkg::REFRESH_BUSY_CYC || REFRESH_PERIOD >= (1 << dps_pkg::REFRESH_CNT_W)) begin : g_check
    $error("REFRESH_PERIOD out of range");
  end

  localparam logic [dps_pkg::REFRESH_CNT_W-1:0] REF_LAST = dps_pkg::REFRESH_CNT_W'(REFRESH_PERIOD - 1);
  localparam logic [2:0] REF_BUSY = 3'(dps_pkg::REFRESH_BUSY_CYC);
  localparam logic [dps_pkg::CA_CNT_W-1:0] CA_LAST = dps_pkg::CA_CNT_W'(dps_pkg::CA_BYTES - 1);
  localparam int AW = dps_pkg::WORD_ADDR_W;

  // pins cross into clk with two flops; sync1 feeds only sync2
  dps_pkg::dps_pins_t sync1_q;
  dps_pkg::dps_pins_t pin_q;
  logic ck_prev_q;
  logic rise;
  logic fall;
  logic abort;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '{dq: 8'h00, read_write_strobe: 1'b0, cs_n: 1'b1, ck: 1'b0, rst_n: 1'b0};
      pin_q <= '{dq: 8'h00, read_write_strobe: 1'b0, cs_n: 1'b1, ck: 1'b0, rst_n: 1'b0};
      ck_prev_q <= 1'b0;
    end else begin
      sync1_q <= '{dq: dq_in, read_write_strobe: read_write_strobe_in, cs_n: cs_n, ck: bus_clock, rst_n: reset_pin_n};
      pin_q <= sync1_q;
      ck_prev_q <= pin_q.ck;
    end
  end

  // both bus clock edges carry a byte
  assign rise = pin_q.ck & ~ck_prev_q;
  assign fall = ~pin_q.ck & ck_prev_q;
  // chip select release ends any transaction reset pin forces idle
  assign abort = pin_q.cs_n | ~pin_q.rst_n;

  // refresh scheduling
  logic [dps_pkg::REFRESH_CNT_W-1:0] ref_timer_q;
  logic ref_due_q;
  logic [2:0] ref_busy_q;
  logic ref_start;
  logic need_extra;
  dps_pkg::dps_state_t state_q;

  // refresh only starts with the bus idle, so it never collides with a burst
  assign ref_start = ref_due_q && ref_busy_q == 3'h0 && state_q == dps_pkg::DPS_IDLE && pin_q.cs_n;
  // dual die never offers single latency
  assign need_extra = DUAL_DIE | ref_due_q | (ref_busy_q != 3'h0);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_timer_q <= '0;
    end else if (ref_timer_q == REF_LAST) begin
      ref_timer_q <= '0;
    end else begin
      ref_timer_q <= ref_timer_q + 1'b1;
    end
  end

  // a new due tick wins over the clear from a refresh start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_due_q <= 1'b0;
    end else if (ref_timer_q == REF_LAST) begin
      ref_due_q <= 1'b1;
    end else if (ref_start) begin
      ref_due_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_busy_q <= 3'h0;
      refresh_active <= 1'b0;
    end else begin
      if (ref_start) begin
        ref_busy_q <= REF_BUSY;
      end else if (ref_busy_q != 3'h0) begin
        ref_busy_q <= ref_busy_q - 1'b1;
      end
      refresh_active <= ref_start | (ref_busy_q > 3'h1);
    end
  end

  // transaction sequencing
  logic [dps_pkg::CA_BITS-1:0] ca_q;
  logic [dps_pkg::CA_BITS-1:0] ca_next;
  logic [dps_pkg::CA_CNT_W-1:0] ca_cnt_q;
  logic [dps_pkg::LAT_CNT_W-1:0] lat_cnt_q;
  logic [dps_pkg::LAT_CNT_W-1:0] lat_total;
  logic extra_q;
  logic read_q;
  logic linear_q;
  logic hybrid_q;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] addr_next;
  logic [dps_pkg::BURST_CNT_W-1:0] burst_cnt_q;
  logic data_rise;
  logic data_fall;
  logic ca_done;

  assign ca_next = {ca_q[dps_pkg::CA_BITS-9:0], pin_q.dq};
  assign ca_done = state_q == dps_pkg::DPS_CA && (rise || fall) && ca_cnt_q == CA_LAST;

  // extra latency doubles the count zero is served as one
  always_comb begin
    lat_total = extra_q ? {cfg_latency, 1'b0} : {1'b0, cfg_latency};
    if (lat_total == '0) begin
      lat_total = dps_pkg::LAT_CNT_W'(1);
    end
  end

  // the edge that ends the count is the first data edge
  assign data_rise = rise && !abort && ((state_q == dps_pkg::DPS_LAT && lat_cnt_q == dps_pkg::LAT_CNT_W'(1))
                     || state_q == dps_pkg::DPS_DATA);
  assign data_fall = fall && !abort && state_q == dps_pkg::DPS_DATA;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= dps_pkg::DPS_IDLE;
      ca_cnt_q <= '0;
      lat_cnt_q <= '0;
    end else if (abort) begin
      state_q <= dps_pkg::DPS_IDLE;
    end else begin
      case (state_q)
        dps_pkg::DPS_IDLE: begin
          state_q <= dps_pkg::DPS_CA;
          ca_cnt_q <= '0;
        end
        dps_pkg::DPS_CA: begin
          if (ca_done) begin
            state_q <= dps_pkg::DPS_LAT;
            lat_cnt_q <= lat_total;
          end else if (rise || fall) begin
            ca_cnt_q <= ca_cnt_q + 1'b1;
          end
        end
        dps_pkg::DPS_LAT: begin
          if (data_rise) begin
            state_q <= dps_pkg::DPS_DATA;
          end else if (rise) begin
            lat_cnt_q <= lat_cnt_q - 1'b1;
          end
        end
        dps_pkg::DPS_DATA: begin
          state_q <= dps_pkg::DPS_DATA;
        end
        default: begin
          state_q <= dps_pkg::DPS_IDLE;
        end
      endcase
    end
  end

  // command capture on each bus clock edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ca_q <= '0;
      extra_q <= 1'b0;
    end else if (state_q == dps_pkg::DPS_IDLE && !abort) begin
      extra_q <= need_extra;
    end else if (state_q == dps_pkg::DPS_CA && (rise || fall)) begin
      ca_q <= ca_next;
    end
  end

  // next word address: wrap inside the group, linear inside the die
  always_comb begin
    logic [AW-1:0] inc;
    logic [AW-1:0] grp_mask;
    logic [AW-1:0] lin;
    inc = addr_q + 1'b1;
    grp_mask = AW'((dps_pkg::WRAP_WORDS_MIN << cfg_wrap) - 1);
    lin = DUAL_DIE ? {addr_q[AW-1], inc[AW-2:0]} : inc;
    if (linear_q) begin
      addr_next = lin;
    end else if (hybrid_q && burst_cnt_q == dps_pkg::BURST_CNT_W'(grp_mask)) begin
      addr_next = (addr_q & ~grp_mask) + grp_mask + 1'b1;
      if (DUAL_DIE) begin
        addr_next[AW-1] = addr_q[AW-1];
      end
    end else begin
      addr_next = (addr_q & ~grp_mask) | (inc & grp_mask);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_q <= 1'b0;
      linear_q <= 1'b0;
      hybrid_q <= 1'b0;
      addr_q <= '0;
      burst_cnt_q <= '0;
    end else if (ca_done && !abort) begin
      read_q <= ca_next[dps_pkg::CA_READ_BIT];
      linear_q <= ca_next[dps_pkg::CA_LINEAR_BIT];
      hybrid_q <= cfg_hybrid;
      addr_q <= {ca_next[dps_pkg::CA_ROW_LSB +: AW - dps_pkg::CA_COL_W], ca_next[dps_pkg::CA_COL_W-1:0]};
      burst_cnt_q <= '0;
    end else if (data_fall) begin
      addr_q <= addr_next;
      burst_cnt_q <= burst_cnt_q + 1'b1;
      if (hybrid_q && addr_next != ((addr_q & ~AW'(1)) | (addr_next & AW'(1))) && !linear_q) begin
        linear_q <= burst_cnt_q == dps_pkg::BURST_CNT_W'((dps_pkg::WRAP_WORDS_MIN << cfg_wrap) - 1);
      end
    end
  end

  // write byte pairing and array requests
  logic [7:0] hi_byte_q;
  logic hi_keep_n_q;
  logic push_valid;
  logic push_ready;
  dps_pkg::dps_mem_req_t push_req;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_byte_q <= '0;
      hi_keep_n_q <= 1'b1;
    end else if (data_rise && !read_q) begin
      hi_byte_q <= pin_q.dq;
      hi_keep_n_q <= pin_q.read_write_strobe;
    end
  end

  // reads prefetch: first word as latency starts, then one per data word
  always_comb begin
    push_valid = 1'b0;
    push_req = '{we: 1'b0, addr: addr_q, data: '0, keep_n: 2'b11};
    if (ca_done && !abort && ca_next[dps_pkg::CA_READ_BIT]) begin
      push_valid = 1'b1;
      push_req.addr = {ca_next[dps_pkg::CA_ROW_LSB +: AW - dps_pkg::CA_COL_W], ca_next[dps_pkg::CA_COL_W-1:0]};
    end else if (data_fall && read_q) begin
      push_valid = 1'b1;
      push_req.addr = addr_next;
    end else if (data_fall) begin
      push_valid = 1'b1;
      push_req.we = 1'b1;
      push_req.data = {hi_byte_q, pin_q.dq};
      push_req.keep_n = {hi_keep_n_q, pin_q.read_write_strobe};
    end
  end

  // a stalled array may fill the buffer; an overrun is flagged, never silent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lost_word <= 1'b0;
    end else if (push_valid && !push_ready) begin
      lost_word <= 1'b1;
    end else if (state_q == dps_pkg::DPS_IDLE && !pin_q.cs_n) begin
      lost_word <= 1'b0;
    end
  end

  dps_fifo #(
    .WIDTH($bits(dps_pkg::dps_mem_req_t)),
    .DEPTH(BUF_DEPTH)
  ) u_req_buf (
    .clk(clk),
    .resetn(resetn),
    .in_valid(push_valid),
    .in_data(push_req),
    .in_ready(push_ready),
    .out_valid(mem_req_valid),
    .out_data(mem_req),
    .out_ready(mem_req_ready)
  );

  // read answer holding
  logic [dps_pkg::WORD_W-1:0] rd_word_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_word_q <= '0;
      mem_rsp_ready <= 1'b0;
    end else begin
      mem_rsp_ready <= 1'b1;
      if (mem_rsp_valid && mem_rsp_ready) begin
        rd_word_q <= mem_rsp_data;
      end
    end
  end

  // pin drivers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_out <= dps_pkg::DQ_RESET;
      dq_oe <= 1'b0;
      read_write_strobe_out <= dps_pkg::READ_WRITE_STROBE_RESET;
      read_write_strobe_oe <= 1'b0;
    end else if (abort) begin
      dq_oe <= 1'b0;
      read_write_strobe_oe <= 1'b0;
      read_write_strobe_out <= dps_pkg::READ_WRITE_STROBE_RESET;
    end else if (state_q == dps_pkg::DPS_IDLE) begin
      read_write_strobe_oe <= 1'b1;
      read_write_strobe_out <= need_extra;
    end else if (ca_done) begin
      // a write hands the strobe to the host for masking
      read_write_strobe_oe <= ca_next[dps_pkg::CA_READ_BIT];
      read_write_strobe_out <= 1'b0;
    end else if (read_q && data_rise) begin
      dq_oe <= 1'b1;
      dq_out <= rd_word_q[15:8];
      read_write_strobe_out <= 1'b1;
    end else if (read_q && data_fall) begin
      dq_out <= rd_word_q[7:0];
      read_write_strobe_out <= 1'b0;
    end
  end

endmodule

// >>> test/dps_bus_slave_monitor.sv
`timescale 1ns/1ps

module dps_bus_slave_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus pins
  input wire logic cs_n,
  input wire logic reset_pin_n,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic read_write_strobe_out,
  input wire logic read_write_strobe_oe,
  // array stream and status
  input wire logic mem_req_valid,
  input wire dps_pkg::dps_mem_req_t mem_req,
  input wire logic mem_req_ready,
  input wire logic refresh_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  pin_reset_release_a: assert property (!reset_pin_n [*4] |-> !dq_oe && !read_write_strobe_oe)
    else $error("pins driven while reset pin low");
  idle_release_a: assert property (cs_n [*5] |-> !dq_oe && !read_write_strobe_oe)
    else $error("pins driven while deselected");
  ca_strobe_a: assert property ($fell(cs_n) && reset_pin_n |-> ##[2:6] (read_write_strobe_oe && read_write_strobe_out))
    else $error("strobe not high in command phase");
  refresh_idle_a: assert property ($rose(refresh_active) |-> !dq_oe && !read_write_strobe_oe)
    else $error("refresh started during transfer");
  refresh_len_a: assert property ($rose(refresh_active) |-> refresh_active [*4] ##1 !refresh_active)
    else $error("refresh length wrong");
  read_strobe_a: assert property ($rose(dq_oe) |-> read_write_strobe_oe && read_write_strobe_out)
    else $error("first read byte without strobe high");
  strobe_edge_a: assert property (dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(read_write_strobe_out))
    else $error("read byte not aligned with strobe edge");
  oe_pair_a: assert property (dq_oe |-> read_write_strobe_oe)
    else $error("data driven without strobe");
  req_hold_a: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req))
    else $error("array request dropped while stalled");
  cover property ($rose(dq_oe));
  cover property ($rose(refresh_active));
  cover property (mem_req_valid && !mem_req_ready);
endmodule

bind dps_bus_slave dps_bus_slave_monitor i_mon (.clk(clk), .resetn(resetn), .cs_n(cs_n), .reset_pin_n(reset_pin_n),
  .dq_out(dq_out), .dq_oe(dq_oe), .read_write_strobe_out(read_write_strobe_out),
  .read_write_strobe_oe(read_write_strobe_oe), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
  .mem_req_ready(mem_req_ready), .refresh_active(refresh_active));

// >>> test/dps_host_model.sv
`timescale 1ns/1ps

module dps_host_model (
  // clock
  input wire logic clk,
  // levels seen on the shared pins
  input wire logic [7:0] dq_seen,
  input wire logic rw_seen,
  // host pins
  output logic bus_clock,
  output logic cs_n,
  output logic [7:0] h_dq,
  output logic h_rw
);
  logic [15:0] wq[$];
  logic [1:0] mq[$];
  logic [7:0] bq[$];
  logic ca_rw;
  initial begin
    bus_clock = 1'b0;
    cs_n = 1'b1;
    h_dq = 8'h00;
    h_rw = 1'b0;
    ca_rw = 1'b0;
  end
  // byte set two clocks before the edge so it sits centred; sample is the previous edge's byte
  task automatic half(input logic [7:0] b, input logic m, output logic [7:0] s);
    h_dq = b;
    h_rw = m;
    repeat (2) @(negedge clk);
    s = dq_seen;
    bus_clock = ~bus_clock;
    repeat (2) @(negedge clk);
  endtask
  task automatic xact(input logic [47:0] ca, input int lat, input int nw);
    logic [7:0] s;
    logic [15:0] w;
    logic [1:0] m;
    cs_n = 1'b0;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      half(ca[47-8*i -: 8], ~h_rw, s);
      if (i == 1) ca_rw = rw_seen;
    end
    // always doubled latency; the last counted rise carries data
    for (int i = 0; i < 2 * (2 * lat - 1); i++) half(~h_dq, ~h_rw, s);
    for (int j = 0; j < 2 * nw; j++) begin
      if (ca[47]) begin
        half(~h_dq, ~h_rw, s);
        if (j > 0) bq.push_back(s);
      end else begin
        if (j % 2 == 0) begin
          w = wq.pop_front();
          m = mq.pop_front();
        end
        half(j % 2 ? w[7:0] : w[15:8], j % 2 ? m[0] : m[1], s);
      end
    end
    if (ca[47]) begin
      repeat (2) @(negedge clk);
      bq.push_back(dq_seen);
    end
    cs_n = 1'b1;
    h_dq = ~h_dq;
    h_rw = ~h_rw;
    repeat (4) @(negedge clk);
  endtask
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic clk, resetn, reset_pin_n, mem_req_ready, mem_rsp_valid, cfg_hybrid, pend_v;
  logic bus_clock, cs_n, dq_oe, rw_out, rw_oe, h_rw, rw_in, mem_req_valid, mem_rsp_ready, refresh_active, lost_word;
  logic [dps_pkg::LAT_W-1:0] cfg_latency;
  dps_pkg::dps_wrap_t cfg_wrap;
  logic [15:0] mem_rsp_data;
  logic [7:0] dq_out, h_dq, dq_in;
  logic [24:0] pend_a;
  dps_pkg::dps_mem_req_t mem_req;
  dps_pkg::dps_mem_req_t reqq[$];
  int miscompares, num_checks;
  assign dq_in = dq_oe ? dq_out : h_dq;
  assign rw_in = rw_oe ? rw_out : h_rw;
  dps_bus_slave #(.DUAL_DIE(1'b1), .REFRESH_PERIOD(200), .BUF_DEPTH(2)) i_dut (.clk(clk), .resetn(resetn),
    .bus_clock(bus_clock), .cs_n(cs_n), .reset_pin_n(reset_pin_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .read_write_strobe_in(rw_in), .read_write_strobe_out(rw_out), .read_write_strobe_oe(rw_oe),
    .cfg_latency(cfg_latency), .cfg_wrap(cfg_wrap), .cfg_hybrid(cfg_hybrid), .mem_req_valid(mem_req_valid),
    .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
    .mem_rsp_ready(mem_rsp_ready), .refresh_active(refresh_active), .lost_word(lost_word));
  dps_host_model i_host (.clk(clk), .dq_seen(dq_in), .rw_seen(rw_in), .bus_clock(bus_clock), .cs_n(cs_n),
    .h_dq(h_dq), .h_rw(h_rw));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [15:0] arr_word(input logic [24:0] a);
    return {a[7:0] ^ 8'h5a, a[7:0]};
  endfunction
  function automatic logic [47:0] ca_of(input logic rd, input logic lin, input logic [24:0] a);
    logic [47:0] c;
    c = 48'h0;
    c[47] = rd;
    c[45] = lin;
    c[37:16] = a[24:3];
    c[2:0] = a[2:0];
    return c;
  endfunction
  // array side: takes requests while mem_req_ready is high, answers reads one clock later
  always @(posedge clk) begin
    if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1) begin
      reqq.push_back(mem_req);
      if (!mem_req.we) begin
        pend_v <= 1'b1;
        pend_a <= mem_req.addr;
      end
    end
  end
  always @(negedge clk) begin
    mem_rsp_valid <= pend_v;
    mem_rsp_data <= pend_v ? arr_word(pend_a) : ~mem_rsp_data;
    pend_v <= 1'b0;
  end
  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [47:0] ca, input int nw, input logic [24:0] ex[$]);
    reqq.delete();
    i_host.bq.delete();
    i_host.xact(ca, 1, nw);
    chk_bit(i_host.ca_rw, 1'b1);
    for (int i = 0; i < nw; i++) begin
      chk_val(reqq[i].addr, ex[i]);
      chk_val({i_host.bq[2*i], i_host.bq[2*i+1]}, arr_word(ex[i]));
    end
  endtask
  task automatic t_write();
    reqq.delete();
    i_host.wq = '{16'h1234, 16'h5678};
    i_host.mq = '{2'b00, 2'b10};
    i_host.xact(ca_of(1'b0, 1'b1, 25'h0000100), 1, 2);
    chk_val(reqq.size(), 2);
    chk_val(reqq[0], {1'b1, 25'h0000100, 16'h1234, 2'b00});
    chk_val(reqq[1], {1'b1, 25'h0000101, 16'h5678, 2'b10});
    chk_bit(mem_rsp_ready, 1'b1);
    $display("write test done");
  endtask
  task automatic t_die();
    rd_chk(ca_of(1'b1, 1'b1, 25'h0ffffff), 2, '{25'h0ffffff, 25'h0000000});
    rd_chk(ca_of(1'b1, 1'b1, 25'h1ffffff), 2, '{25'h1ffffff, 25'h1000000});
    $display("die wrap test done");
  endtask
  task automatic t_wraps();
    for (int w = 0; w < 4; w++) begin
      cfg_wrap = dps_pkg::dps_wrap_t'(w);
      rd_chk(ca_of(1'b1, 1'b0, 25'h200 + (8 << w) - 1), 2, '{25'h200 + (8 << w) - 1, 25'h200});
    end
    $display("wrap test done");
  endtask
  task automatic t_hybrid();
    logic [24:0] ex[$];
    cfg_wrap = dps_pkg::DPS_WRAP_16B;
    cfg_hybrid = 1'b1;
    for (int i = 0; i < 8; i++) ex.push_back(25'h200 + ((5 + i) % 8));
    ex.push_back(25'h208);
    rd_chk(ca_of(1'b1, 1'b0, 25'h205), 9, ex);
    cfg_hybrid = 1'b0;
    $display("hybrid test done");
  endtask
  task automatic t_stall();
    reqq.delete();
    mem_req_ready = 1'b0;
    i_host.wq = '{16'h0a0b, 16'h0c0d, 16'h0e0f};
    i_host.mq = '{2'b00, 2'b00, 2'b00};
    i_host.xact(ca_of(1'b0, 1'b1, 25'h0000300), 1, 3);
    chk_bit(mem_req_valid, 1'b1);
    chk_bit(lost_word, 1'b1);
    mem_req_ready = 1'b1;
    repeat (6) @(negedge clk);
    chk_val(reqq.size(), 2);
    chk_val(reqq[0].data, 16'h0a0b);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    chk_bit(lost_word, 1'b0);
    $display("stall test done");
  endtask
  task automatic t_refresh();
    int n;
    n = 0;
    for (int i = 0; i < 600 && refresh_active !== 1'b1; i++) @(negedge clk);
    while (refresh_active === 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    chk_val(n, 4);
    $display("refresh test done");
  endtask
  task automatic t_reset_pin();
    fork
      i_host.xact(ca_of(1'b1, 1'b1, 25'h0000400), 1, 4);
      begin
        repeat (50) @(negedge clk);
        chk_bit(dq_oe, 1'b1);
        reset_pin_n = 1'b0;
        repeat (5) @(negedge clk);
        chk_bit(dq_oe, 1'b0);
        chk_bit(rw_oe, 1'b0);
      end
    join
    reset_pin_n = 1'b1;
    repeat (8) @(negedge clk);
    $display("reset pin test done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    miscompares = 0;
    num_checks = 0;
    resetn = 1'b0;
    reset_pin_n = 1'b1;
    mem_req_ready = 1'b1;
    mem_rsp_valid = 1'b0;
    mem_rsp_data = 16'h0000;
    pend_v = 1'b0;
    pend_a = 25'h0;
    cfg_latency = 4'h1;
    cfg_wrap = dps_pkg::DPS_WRAP_16B;
    cfg_hybrid = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    t_write();
    t_die();
    t_wraps();
    t_hybrid();
    t_stall();
    t_refresh();
    t_reset_pin();
    print_verdict();
  end
endmodule
